// ---- hw/mode_ctrl_pkg.sv ----
// package: command codes, modes, response kinds and timing for the reader mode controller
package mode_ctrl_pkg;

  // -----------------------------------------------------------------
  // modes and owners
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DATA = 2'b00,
    MODE_CMD = 2'b01,
    MODE_DNLD = 2'b10,
    MODE_BOOT = 2'b11
  } mode_t;

  // -----------------------------------------------------------------
  // decoded command kinds
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_TO_DATA = 4'h0,
    CMD_TO_CMD = 4'h1,
    CMD_TO_DNLD = 4'h2,
    CMD_BAUD = 4'h3,
    CMD_LOAD = 4'h4,
    CMD_VERIFY = 4'h5,
    CMD_ERASE = 4'h6,
    CMD_MEMTEST = 4'h7,
    CMD_EXIT_DNLD = 4'h8,
    CMD_OTHER = 4'h9,
    CMD_BAD = 4'hf
  } cmd_kind_t;

  typedef enum logic [1:0] {
    RSP_DONE = 2'b00,
    RSP_ERROR = 2'b01,
    RSP_DATA = 2'b10
  } rsp_kind_t;

  // -----------------------------------------------------------------
  // command digit codes (two hex digits after the start character)
  // -----------------------------------------------------------------
  localparam logic [7:0] CODE_TO_DATA = 8'h00;
  localparam logic [7:0] CODE_TO_CMD = 8'h01;
  localparam logic [7:0] CODE_TO_DNLD = 8'h05;
  localparam logic [7:0] CODE_LOAD = 8'h90;
  localparam logic [7:0] CODE_VERIFY = 8'h91;
  localparam logic [7:0] CODE_ERASE = 8'h96;
  localparam logic [7:0] CODE_MEMTEST = 8'h97;
  localparam logic [7:0] CODE_EXIT_DNLD = 8'h99;
  localparam logic [7:0] CODE_BAUD_HI = 8'h10;
  localparam logic [3:0] CODE_BAUD_LO = 4'h0;

  // -----------------------------------------------------------------
  // serial settings
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] baud_sel;
    logic two_stop;
    logic [1:0] parity;
    logic xon_xoff;
    logic basic_proto;
  } serial_cfg_t;

  localparam logic [2:0] BAUD_SEL_9600 = 3'h5;
  localparam logic [2:0] BAUD_SEL_MIN = 3'h2;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h7;
  localparam serial_cfg_t DNLD_CFG = '{baud_sel: 3'h5, two_stop: 1'b0, parity: 2'h0,
                                       xon_xoff: 1'b1, basic_proto: 1'b1};
  localparam serial_cfg_t RESET_CFG = '{baud_sel: 3'h5, two_stop: 1'b0, parity: 2'h0,
                                        xon_xoff: 1'b0, basic_proto: 1'b0};

  // -----------------------------------------------------------------
  // a parsed command arriving from the framing logic
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] arg;
    logic has_arg;
  } cmd_t;

  typedef struct packed {
    rsp_kind_t kind;
    logic [7:0] code;
  } rsp_t;

  // -----------------------------------------------------------------
  // interrupt status bit positions
  // -----------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_MODE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_BOOT = 3;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_STAT = 4'h1;
  localparam logic [3:0] REG_IRQ_CLR = 4'h2;
  localparam logic [3:0] REG_IRQ_EN = 4'h3;
  localparam logic [3:0] REG_CFG = 4'h4;
  localparam logic [3:0] REG_DROPS = 4'h5;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;

  // -----------------------------------------------------------------
  // timing: startup checks take a fixed time
  // -----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_US = 20;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam logic [15:0] STARTUP_CYC_W = 16'(STARTUP_CYC);

endpackage

// ---- hw/reader_mode_ctrl.sv ----
// reader mode controller: mode machine, command gating, responses, tag gating and serial settings
module reader_mode_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  // parsed commands from the framing logic
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_char_hi,
  input wire logic [7:0] cmd_char_lo,
  input wire logic [7:0] cmd_char_arg,
  input wire logic cmd_has_arg,
  // response towards the transmitter
  output logic rsp_valid,
  output mode_ctrl_pkg::rsp_t rsp,
  input wire logic rsp_sent,
  // data-mode messages from tag decode and sensors
  input wire logic tag_valid,
  input wire logic [63:0] tag_id,
  input wire logic sensor_input_a,
  input wire logic sensor_input_b,
  input wire logic presence_no_tag,
  input wire logic buf_overflow,
  output logic msg_valid,
  output logic [2:0] msg_kind,
  output logic [63:0] msg_data,
  // radio, echo and serial settings
  output logic rf_on,
  output logic tag_acq_en,
  output logic echo_en,
  output mode_ctrl_pkg::serial_cfg_t serial_cfg,
  output logic boot_owner,
  output logic startup_run,
  input wire logic startup_ok,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // -----------------------------------------------------------------
  // hex digit decode
  // -----------------------------------------------------------------
  // either case of a-f
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h10;
    if (c >= 8'h30 && c <= 8'h39) begin
      v = {1'b0, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      v = {1'b0, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      v = {1'b0, 4'(c - 8'h57)};
    end
    return v;
  endfunction

  function automatic mode_ctrl_pkg::cmd_kind_t decode(input mode_ctrl_pkg::cmd_t c);
    mode_ctrl_pkg::cmd_kind_t k;
    k = mode_ctrl_pkg::CMD_OTHER;
    case (c.code)
      mode_ctrl_pkg::CODE_TO_DATA: k = mode_ctrl_pkg::CMD_TO_DATA;
      mode_ctrl_pkg::CODE_TO_CMD: k = mode_ctrl_pkg::CMD_TO_CMD;
      mode_ctrl_pkg::CODE_TO_DNLD: k = mode_ctrl_pkg::CMD_TO_DNLD;
      mode_ctrl_pkg::CODE_LOAD: k = mode_ctrl_pkg::CMD_LOAD;
      mode_ctrl_pkg::CODE_VERIFY: k = mode_ctrl_pkg::CMD_VERIFY;
      mode_ctrl_pkg::CODE_ERASE: k = mode_ctrl_pkg::CMD_ERASE;
      mode_ctrl_pkg::CODE_MEMTEST: k = mode_ctrl_pkg::CMD_MEMTEST;
      mode_ctrl_pkg::CODE_EXIT_DNLD: k = mode_ctrl_pkg::CMD_EXIT_DNLD;
      mode_ctrl_pkg::CODE_BAUD_HI: k = mode_ctrl_pkg::CMD_BAUD;
      default: k = mode_ctrl_pkg::CMD_OTHER;
    endcase
    return k;
  endfunction

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  logic [4:0] hv_hi;
  logic [4:0] hv_lo;
  logic [4:0] hv_arg;
  mode_ctrl_pkg::cmd_t cmd;
  mode_ctrl_pkg::cmd_kind_t kind;
  logic bad_chars;

  always_comb begin
    hv_hi = hex_val(cmd_char_hi);
    hv_lo = hex_val(cmd_char_lo);
    hv_arg = hex_val(cmd_char_arg);
    cmd.code = {hv_hi[3:0], hv_lo[3:0]};
    cmd.arg = hv_arg[3:0];
    cmd.has_arg = cmd_has_arg;
    bad_chars = hv_hi[4] | hv_lo[4] | (cmd_has_arg & hv_arg[4]);
    kind = bad_chars ? mode_ctrl_pkg::CMD_BAD : decode(cmd);
  end

  // -----------------------------------------------------------------
  // mode machine
  // -----------------------------------------------------------------
  mode_ctrl_pkg::mode_t mode_r;
  mode_ctrl_pkg::mode_t mode_nxt;
  logic accept;
  logic answer;
  logic baud_take;
  logic startup_go;
  logic [15:0] startup_cnt_r;
  logic startup_done;
  mode_ctrl_pkg::rsp_kind_t rkind;

  assign startup_done = startup_run && (startup_cnt_r == 16'h0000) && startup_ok;

  always_comb begin
    mode_nxt = mode_r;
    accept = 1'b0;
    answer = 1'b0;
    baud_take = 1'b0;
    startup_go = 1'b0;
    rkind = mode_ctrl_pkg::RSP_ERROR;
    case (mode_r)
      mode_ctrl_pkg::MODE_DATA: begin
        // only command switch; download refused here
        if (cmd_valid && kind == mode_ctrl_pkg::CMD_TO_CMD) begin
          accept = 1'b1;
          answer = 1'b1;
          rkind = mode_ctrl_pkg::RSP_DONE;
          mode_nxt = mode_ctrl_pkg::MODE_CMD;
        end
      end
      mode_ctrl_pkg::MODE_CMD: begin
        if (cmd_valid) begin
          answer = 1'b1;
          case (kind)
            mode_ctrl_pkg::CMD_TO_DATA: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DONE;
              mode_nxt = mode_ctrl_pkg::MODE_DATA;
            end
            mode_ctrl_pkg::CMD_TO_CMD: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DONE;
            end
            mode_ctrl_pkg::CMD_TO_DNLD: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DONE;
              mode_nxt = mode_ctrl_pkg::MODE_DNLD;
            end
            mode_ctrl_pkg::CMD_BAUD: begin
              if (cmd.has_arg && cmd.arg[3] == 1'b0 && cmd.arg[2:0] >= mode_ctrl_pkg::BAUD_SEL_MIN) begin
                accept = 1'b1;
                baud_take = 1'b1;
                rkind = mode_ctrl_pkg::RSP_DONE;
              end
            end
            mode_ctrl_pkg::CMD_OTHER: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DATA;
            end
            default: rkind = mode_ctrl_pkg::RSP_ERROR;
          endcase
        end
      end
      mode_ctrl_pkg::MODE_DNLD: begin
        if (cmd_valid) begin
          answer = 1'b1;
          case (kind)
            mode_ctrl_pkg::CMD_LOAD, mode_ctrl_pkg::CMD_VERIFY, mode_ctrl_pkg::CMD_ERASE,
            mode_ctrl_pkg::CMD_MEMTEST: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DONE;
            end
            mode_ctrl_pkg::CMD_EXIT_DNLD: begin
              accept = 1'b1;
              rkind = mode_ctrl_pkg::RSP_DONE;
              startup_go = 1'b1;
              mode_nxt = mode_ctrl_pkg::MODE_BOOT;
            end
            default: rkind = mode_ctrl_pkg::RSP_ERROR;
          endcase
        end
      end
      mode_ctrl_pkg::MODE_BOOT: begin
        if (startup_done) begin
          mode_nxt = mode_ctrl_pkg::MODE_DATA;
        end
      end
      default: mode_nxt = mode_ctrl_pkg::MODE_DATA;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= mode_ctrl_pkg::MODE_DATA;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // -----------------------------------------------------------------
  // startup sequencer
  // -----------------------------------------------------------------
  // boot side owns startup and download
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      startup_run <= 1'b0;
      startup_cnt_r <= 16'h0000;
    end else if (startup_go) begin
      startup_run <= 1'b1;
      startup_cnt_r <= mode_ctrl_pkg::STARTUP_CYC_W;
    end else if (startup_done) begin
      startup_run <= 1'b0;
    end else if (startup_run && startup_cnt_r != 16'h0000) begin
      startup_cnt_r <= startup_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_owner <= 1'b0;
    end else begin
      boot_owner <= (mode_nxt == mode_ctrl_pkg::MODE_DNLD) || (mode_nxt == mode_ctrl_pkg::MODE_BOOT);
    end
  end

  // -----------------------------------------------------------------
  // response
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp <= '{kind: mode_ctrl_pkg::RSP_DONE, code: 8'h00};
    end else if (answer) begin
      rsp_valid <= 1'b1;
      rsp <= '{kind: rkind, code: cmd.code};
    end else if (rsp_sent) begin
      rsp_valid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // serial settings
  // -----------------------------------------------------------------
  mode_ctrl_pkg::serial_cfg_t cfg_r;
  logic [2:0] baud_pend_r;
  logic baud_pend_valid_r;

  // new rate waits for done to leave
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baud_pend_r <= mode_ctrl_pkg::BAUD_SEL_9600;
      baud_pend_valid_r <= 1'b0;
      cfg_r <= mode_ctrl_pkg::RESET_CFG;
    end else begin
      if (baud_take) begin
        baud_pend_r <= cmd.arg[2:0];
        baud_pend_valid_r <= 1'b1;
      end else if (baud_pend_valid_r && rsp_sent) begin
        cfg_r.baud_sel <= baud_pend_r;
        baud_pend_valid_r <= 1'b0;
      end
      if (reg_wr && reg_addr == mode_ctrl_pkg::REG_CFG) begin
        cfg_r.two_stop <= reg_wdata[3];
        cfg_r.parity <= reg_wdata[5:4];
        cfg_r.xon_xoff <= reg_wdata[6];
        cfg_r.basic_proto <= reg_wdata[7];
      end
    end
  end

  // fixed settings while boot side runs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_cfg <= mode_ctrl_pkg::RESET_CFG;
    end else if (mode_r == mode_ctrl_pkg::MODE_DNLD || mode_r == mode_ctrl_pkg::MODE_BOOT) begin
      serial_cfg <= mode_ctrl_pkg::DNLD_CFG;
    end else begin
      serial_cfg <= cfg_r;
    end
  end

  // -----------------------------------------------------------------
  // radio, tag gating, echo
  // -----------------------------------------------------------------
  logic in_data;
  assign in_data = (mode_nxt == mode_ctrl_pkg::MODE_DATA);

  // radio off outside data mode; and no echo in download
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rf_on <= 1'b1;
      tag_acq_en <= 1'b1;
      echo_en <= 1'b1;
    end else begin
      rf_on <= in_data;
      tag_acq_en <= in_data;
      echo_en <= (mode_nxt != mode_ctrl_pkg::MODE_DNLD) && (mode_nxt != mode_ctrl_pkg::MODE_BOOT);
    end
  end

  // -----------------------------------------------------------------
  // data-mode messages
  // -----------------------------------------------------------------
  logic sens_a_r;
  logic sens_b_r;
  logic sens_chg;
  logic drop;
  logic [15:0] drops_r;

  assign sens_chg = (sensor_input_a != sens_a_r) || (sensor_input_b != sens_b_r);
  assign drop = tag_valid && (mode_r != mode_ctrl_pkg::MODE_DATA);

  // forward tags and reports; drop tags elsewhere
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      msg_valid <= 1'b0;
      msg_kind <= 3'h0;
      msg_data <= 64'h0;
      sens_a_r <= 1'b0;
      sens_b_r <= 1'b0;
    end else begin
      sens_a_r <= sensor_input_a;
      sens_b_r <= sensor_input_b;
      msg_valid <= 1'b0;
      if (mode_r == mode_ctrl_pkg::MODE_DATA) begin
        if (tag_valid) begin
          msg_valid <= 1'b1;
          msg_kind <= 3'h0;
          msg_data <= tag_id;
        end else if (sens_chg) begin
          msg_valid <= 1'b1;
          msg_kind <= 3'h1;
          msg_data <= {62'h0, sensor_input_b, sensor_input_a};
        end else if (presence_no_tag) begin
          msg_valid <= 1'b1;
          msg_kind <= 3'h2;
          msg_data <= 64'h0;
        end else if (buf_overflow) begin
          msg_valid <= 1'b1;
          msg_kind <= 3'h3;
          msg_data <= 64'h0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drops_r <= 16'h0000;
    end else if (drop && drops_r != 16'hffff) begin
      drops_r <= drops_r + 16'h0001;
    end
  end

  // -----------------------------------------------------------------
  // interrupts and registers
  // -----------------------------------------------------------------
  logic [mode_ctrl_pkg::IRQ_W-1:0] irq_stat_r;
  logic [mode_ctrl_pkg::IRQ_W-1:0] irq_en_r;
  logic [mode_ctrl_pkg::IRQ_W-1:0] irq_set;
  logic [mode_ctrl_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[mode_ctrl_pkg::IRQ_MODE] = (mode_nxt != mode_r);
    irq_set[mode_ctrl_pkg::IRQ_ERR] = answer && (rkind == mode_ctrl_pkg::RSP_ERROR);
    irq_set[mode_ctrl_pkg::IRQ_DROP] = drop;
    irq_set[mode_ctrl_pkg::IRQ_BOOT] = startup_done;
    irq_clr = (reg_wr && reg_addr == mode_ctrl_pkg::REG_IRQ_CLR) ? reg_wdata[mode_ctrl_pkg::IRQ_W-1:0] : '0;
  end

  // set beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= '0;
      irq_en_r <= mode_ctrl_pkg::IRQ_EN_RESET;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (reg_wr && reg_addr == mode_ctrl_pkg::REG_IRQ_EN) begin
        irq_en_r <= reg_wdata[mode_ctrl_pkg::IRQ_W-1:0];
      end
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        mode_ctrl_pkg::REG_STATUS: reg_rdata <= {26'h0, baud_pend_valid_r, startup_run, rf_on, boot_owner, mode_r};
        mode_ctrl_pkg::REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_r};
        mode_ctrl_pkg::REG_IRQ_EN: reg_rdata <= {28'h0, irq_en_r};
        mode_ctrl_pkg::REG_CFG: reg_rdata <= {24'h0, cfg_r.basic_proto, cfg_r.xon_xoff, cfg_r.parity, cfg_r.two_stop,
                                              cfg_r.baud_sel};
        mode_ctrl_pkg::REG_DROPS: reg_rdata <= {16'h0, drops_r};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

// ---- tb/host_model.sv ----
// host side model: acknowledges each response after a chosen wait
module host_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rsp_valid,
  input wire logic [3:0] wait_cyc,
  output logic rsp_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;

  // ack only after the whole response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 4'h0;
      rsp_sent <= 1'b0;
    end else begin
      rsp_sent <= rsp_valid && !rsp_sent && wait_r == wait_cyc;
      wait_r <= (rsp_valid && !rsp_sent && wait_r != wait_cyc) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// ---- tb/reader_mode_chk.sv ----
// checker: port-level properties of the reader mode controller
module reader_mode_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_char_hi,
  input wire logic [7:0] cmd_char_lo,
  input wire logic rsp_valid,
  input wire mode_ctrl_pkg::rsp_t rsp,
  input wire logic rsp_sent,
  input wire logic tag_valid,
  input wire logic msg_valid,
  input wire logic [2:0] msg_kind,
  input wire logic rf_on,
  input wire logic tag_acq_en,
  input wire logic echo_en,
  input wire mode_ctrl_pkg::serial_cfg_t serial_cfg,
  input wire logic boot_owner,
  input wire logic startup_run,
  input wire logic startup_ok
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic [15:0] pair = {cmd_char_hi, cmd_char_lo};
  wire logic cmd_mode = !rf_on && !boot_owner;
  logic [15:0] run_r;

  // startup length counter, cleared whenever the check is idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 16'h0;
    end else begin
      run_r <= startup_run ? run_r + 16'h1 : 16'h0;
    end
  end

  reset_state_a: assert property (!$past(rstn) |->
    rf_on && tag_acq_en && echo_en && !rsp_valid && !boot_owner) else $error("bad state after reset");
  data_switch_a: assert property (rf_on && cmd_valid && pair == 16'h3031 |=>
    rsp_valid && rsp.kind == mode_ctrl_pkg::RSP_DONE && !rf_on && !tag_acq_en) else $error("switch failed");
  data_ignore_a: assert property (rf_on && cmd_valid && pair != 16'h3031 && !rsp_valid |=>
    rf_on && !rsp_valid) else $error("data mode took a command");
  cmd_to_data_a: assert property (cmd_mode && cmd_valid && pair == 16'h3030 |=>
    rf_on && tag_acq_en && rsp.kind == mode_ctrl_pkg::RSP_DONE) else $error("return to data failed");
  bad_cmd_a: assert property (cmd_mode && cmd_valid && pair == 16'h3930 |=>
    rsp.kind == mode_ctrl_pkg::RSP_ERROR && cmd_mode) else $error("bad command not refused");
  tag_fwd_a: assert property (tag_valid && rf_on |=> msg_valid && msg_kind == 3'h0)
    else $error("tag not forwarded");
  tag_drop_a: assert property (tag_valid && !rf_on |=> !msg_valid)
    else $error("tag leaked outside data mode");
  dnld_quiet_a: assert property (boot_owner |-> !rf_on && !tag_acq_en && !echo_en)
    else $error("download mode not quiet");
  dnld_cfg_a: assert property (cmd_mode && cmd_valid && pair == 16'h3035 |=>
    boot_owner ##1 serial_cfg == mode_ctrl_pkg::DNLD_CFG) else $error("download settings wrong");
  startup_len_a: assert property ($fell(startup_run) |-> run_r > mode_ctrl_pkg::STARTUP_CYC_W)
    else $error("startup ended early");
  startup_end_a: assert property (startup_run && startup_ok && run_r >= mode_ctrl_pkg::STARTUP_CYC_W |=>
    !startup_run && !boot_owner && rf_on) else $error("startup did not hand over");
  baud_hold_a: assert property (rsp_valid && !rsp_sent && !cmd_valid && cmd_mode && $past(cmd_mode) |=>
    $stable(serial_cfg.baud_sel)) else $error("rate changed before response sent");
endmodule

bind reader_mode_ctrl reader_mode_chk chk_i (.*);

// ---- tb/tb_top.sv ----
// testbench: mode switching, gating, responses, interrupts and download exit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_has_arg = 1'b0, tag_valid = 1'b0;
  logic [7:0] cmd_char_hi = 8'h30, cmd_char_lo = 8'h30, cmd_char_arg = 8'h30;
  logic sensor_input_a = 1'b0, sensor_input_b = 1'b0, presence_no_tag = 1'b0, buf_overflow = 1'b0;
  logic [63:0] tag_id = 64'h0, msg_data;
  logic rsp_valid, rsp_sent, msg_valid, rf_on, tag_acq_en, echo_en, boot_owner, startup_run, irq;
  logic startup_ok = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, host_wait = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] msg_kind;
  mode_ctrl_pkg::rsp_t rsp;
  mode_ctrl_pkg::serial_cfg_t serial_cfg;
  int failures = 0, cmp_count = 0, cyc = 0;

  reader_mode_ctrl dut (.*);
  host_model host (.core_clk, .rstn, .rsp_valid, .wait_cyc(host_wait), .rsp_sent);

  always #5 core_clk = ~core_clk;

  // a hang ends the run as a failure
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // gap first so the host has acknowledged the previous response
  task automatic cmd(input logic [15:0] pair, input logic [7:0] arg = 8'h30, input logic has = 1'b0);
    repeat (8) @(posedge core_clk);
    {cmd_valid, cmd_char_hi, cmd_char_lo, cmd_char_arg, cmd_has_arg} <= {1'b1, pair, arg, has};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic tag(input logic exp_msg);
    @(posedge core_clk);
    {tag_valid, tag_id} <= {1'b1, 64'h0123_4567_89ab_cdef};
    @(posedge core_clk);
    tag_valid <= 1'b0;
    #1 chk({msg_valid, msg_kind}, {exp_msg, 3'h0});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk({rf_on, tag_acq_en, echo_en, boot_owner, rsp_valid}, 5'b11100);
    chk(serial_cfg, mode_ctrl_pkg::RESET_CFG);
    rd(mode_ctrl_pkg::REG_STATUS, 32'h8);
    rd(mode_ctrl_pkg::REG_IRQ_EN, 32'h0);
    rd(mode_ctrl_pkg::REG_CFG, 32'h5);
    rd(4'hf, 32'h0);
    $display("test reset finished");
  endtask

  task automatic t_data;
    // sensor change outranks presence; presence and overflow are then reported one at a time
    @(posedge core_clk);
    {sensor_input_b, presence_no_tag} <= 2'b11;
    @(posedge core_clk);
    #1 chk({msg_valid, msg_kind}, {1'b1, 3'h1});
    chk(msg_data, 64'h2);
    @(posedge core_clk);
    {presence_no_tag, buf_overflow} <= 2'b01;
    #1 chk({msg_valid, msg_kind}, {1'b1, 3'h2});
    @(posedge core_clk);
    buf_overflow <= 1'b0;
    #1 chk({msg_valid, msg_kind}, {1'b1, 3'h3});
    tag(1'b1);
    cmd(16'h3035);
    chk({rsp_valid, rf_on}, 2'b01);
    cmd(16'h3030);
    chk({rsp_valid, rf_on}, 2'b01);
    cmd(16'h3031);
    chk({rsp_valid, rsp.kind, rf_on, tag_acq_en}, {1'b1, mode_ctrl_pkg::RSP_DONE, 2'b00});
    $display("test data mode finished");
  endtask

  task automatic t_cmd;
    wr(mode_ctrl_pkg::REG_IRQ_CLR, 32'hf);
    wr(mode_ctrl_pkg::REG_IRQ_EN, 32'h4);
    tag(1'b0);
    rd(mode_ctrl_pkg::REG_DROPS, 32'h1);
    settle(3);
    chk(irq, 1'b1);
    rd(mode_ctrl_pkg::REG_IRQ_STAT, 32'h4);
    wr(mode_ctrl_pkg::REG_IRQ_EN, 32'h0);
    settle(2);
    chk(irq, 1'b0);
    wr(mode_ctrl_pkg::REG_IRQ_CLR, 32'h4);
    rd(mode_ctrl_pkg::REG_IRQ_STAT, 32'h0);
    cmd(16'h3661);
    chk({rsp.kind, rsp.code}, {mode_ctrl_pkg::RSP_DATA, 8'h6a});
    cmd(16'h3641);
    chk({rsp.kind, rsp.code}, {mode_ctrl_pkg::RSP_DATA, 8'h6a});
    cmd(16'h3067);
    chk({rsp_valid, rsp.kind}, {1'b1, mode_ctrl_pkg::RSP_ERROR});
    cmd(16'h3930);
    chk(rsp.kind, mode_ctrl_pkg::RSP_ERROR);
    cmd(16'h3130, 8'h38, 1'b1);
    chk(rsp.kind, mode_ctrl_pkg::RSP_ERROR);
    host_wait <= 4'h4;
    cmd(16'h3130, 8'h37, 1'b1);
    chk({rsp.kind, serial_cfg.baud_sel}, {mode_ctrl_pkg::RSP_DONE, 3'h5});
    settle(12);
    chk(serial_cfg.baud_sel, 3'h7);
    cmd(16'h3030);
    chk({rsp.kind, rf_on}, {mode_ctrl_pkg::RSP_DONE, 1'b1});
    tag(1'b1);
    cmd(16'h3031);
    $display("test command mode finished");
  endtask

  task automatic t_dnld;
    logic [15:0] ok_codes [4] = '{16'h3930, 16'h3931, 16'h3936, 16'h3937};
    cmd(16'h3035);
    chk({rsp.kind, boot_owner, echo_en, rf_on}, {mode_ctrl_pkg::RSP_DONE, 3'b100});
    settle(1);
    chk(serial_cfg, mode_ctrl_pkg::DNLD_CFG);
    tag(1'b0);
    foreach (ok_codes[i]) begin
      cmd(ok_codes[i]);
      chk({rsp.kind, boot_owner}, {mode_ctrl_pkg::RSP_DONE, 1'b1});
    end
    cmd(16'h3031);
    chk({rsp.kind, boot_owner}, {mode_ctrl_pkg::RSP_ERROR, 1'b1});
    cmd(16'h3939);
    settle(1);
    chk({rsp.kind, startup_run}, {mode_ctrl_pkg::RSP_DONE, 1'b1});
    // the timed checks expire, but hand-over still waits for the pass flag
    settle(2010);
    chk({startup_run, rf_on, boot_owner}, 3'b101);
    @(posedge core_clk);
    startup_ok <= 1'b1;
    settle(4);
    chk({rf_on, boot_owner, echo_en, startup_run}, 4'b1010);
    $display("test download mode finished");
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_data();
    t_cmd();
    t_dnld();
    end_sim();
  end
endmodule
